// file: bench/bus_ctl_props.sv
// Checker on the bus control ports
`timescale 1ns/1ps
module bus_ctl_props (
	input wire logic                   REF_CLK,
	input wire logic                   RESETN,
	input wire logic                   BUS_REQUEST,
	input wire bus_ctl_pkg::ctl_pins_s CTL_O,
	input wire bus_ctl_pkg::ctl_pins_s CTL_OE,
	input wire logic                   IRQ_ACK_STROBE_N,
	input wire logic                   ADDR_LATCH,
	input wire logic                   BUS_GRANT
);
	import bus_ctl_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	// A read-type enable trails its strobe by one half T-state
	sequence s_enable_late;
		CTL_O.xcvr_enable_n[*5] ##1 CTL_O.xcvr_enable_n[*5] ##1 !CTL_O.xcvr_enable_n;
	endsequence
	sequence s_latch_half;
		ADDR_LATCH[*5] ##1 ADDR_LATCH[*5] ##1 !ADDR_LATCH;
	endsequence
	a_latch_pulse: assert property ($rose(ADDR_LATCH) |-> s_latch_half)
		else $error("address latch pulse length wrong");
	a_grant_float: assert property (BUS_GRANT |-> CTL_OE == CTL_NO_OE && CTL_O == CTL_IDLE)
		else $error("control pins driven during grant");
	a_grant_quiet: assert property (BUS_GRANT |-> IRQ_ACK_STROBE_N && !ADDR_LATCH)
		else $error("strobe active during grant");
	a_read_enable: assert property ($fell(CTL_O.read_strobe_n) |-> s_enable_late)
		else $error("read enable not at mid T2");
	a_ack_enable: assert property ($fell(IRQ_ACK_STROBE_N) |-> s_enable_late)
		else $error("acknowledge enable not at mid T2");
	a_write_enable: assert property ($fell(CTL_O.write_strobe_n)
		|-> $fell(CTL_O.xcvr_enable_n) && CTL_O.xcvr_direction)
		else $error("write enable or direction wrong");
	a_read_dir: assert property (!CTL_O.read_strobe_n || !IRQ_ACK_STROBE_N
		|-> !CTL_O.xcvr_direction)
		else $error("receive direction wrong");
	a_grant_cause: assert property ($rose(BUS_GRANT) |-> $past(BUS_REQUEST, 3))
		else $error("grant without request");
	a_grant_release: assert property ($fell(BUS_GRANT) |-> !$past(BUS_REQUEST, 3))
		else $error("grant dropped while requested");
endmodule

// file: bench/far_side_model.sv
// Far side: memory ready timing and a second bus master
`timescale 1ns/1ps
module far_side_model (
	input  wire logic                   ref_clk,
	input  wire bus_ctl_pkg::ctl_pins_s ctl_o,
	input  wire logic                   ack_n,
	input  wire logic                   grant,
	input  wire logic [1:0]             n_waits,
	input  wire logic                   want,
	output      logic                   ready_in,
	output      logic                   bus_req
);
	int low_cnt = 0;
	initial ready_in = 1'b0;
	initial bus_req = 1'b0;
	// Ready rises mid T-state so its sample point is far from the change
	always @(negedge ref_clk) begin
		if (!ctl_o.read_strobe_n || !ctl_o.write_strobe_n || !ack_n)
			low_cnt = low_cnt + 1;
		else
			low_cnt = 0;
		ready_in <= low_cnt >= 30 + 20 * n_waits;
		bus_req <= want || (bus_req && !grant);
	end
endmodule

// file: bench/min_mode_bus_control_test.sv
// Self-checking testbench for the minimum-mode bus control block
`timescale 1ns/1ps
module min_mode_bus_control_test;
	import bus_ctl_pkg::*;
	typedef struct packed {
		logic [1:0] waits;
		logic       sel;
		logic       dir;
		logic [7:0] rd_len;
		logic [7:0] wr_len;
		logic [7:0] ack_len;
		logic [7:0] en_len;
	} note_s;
	logic      ref_clk, resetn, cfg_pin, bus_req, ready_in, req_valid, req_ready, cycle_done;
	logic      ack_n, ale, grant, want, ale_d, m_sel, m_dir;
	logic [1:0] n_waits;
	logic [7:0] rd, wr, ak, en;
	cycle_e    req_kind;
	ctl_pins_s ctl_o, ctl_oe;
	note_s     exp_q[$];
	note_s     cur;
	int        num_errors = 0;
	int        n_checks = 0;
	cycle_e    kinds[5] = '{CYC_IRQ_ACK, CYC_IO_RD, CYC_IO_WR, CYC_MEM_RD, CYC_MEM_WR};

	min_mode_bus_control dut (.REF_CLK(ref_clk), .RESETN(resetn), .BUS_CONFIG_PIN(cfg_pin),
		.BUS_REQUEST(bus_req), .READY_IN(ready_in), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
		.REQ_READY(req_ready), .CYCLE_DONE(cycle_done), .CTL_O(ctl_o), .CTL_OE(ctl_oe),
		.IRQ_ACK_STROBE_N(ack_n), .ADDR_LATCH(ale), .BUS_GRANT(grant));
	far_side_model far (.ref_clk(ref_clk), .ctl_o(ctl_o), .ack_n(ack_n), .grant(grant),
		.n_waits(n_waits), .want(want), .ready_in(ready_in), .bus_req(bus_req));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task end_sim;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: return req_ready;
			1: return grant;
			3: return ale;
			default: return exp_q.size() == 0;
		endcase
	endfunction

	task automatic waitfor(input int w, input logic v);
		int n;
		for (n = 0; n < 3000 && sig(w) !== v; n++)
			@(negedge ref_clk);
		if (n == 3000) begin
			num_errors++;
			end_sim();
		end
	endtask

	// Strobe spans T2, T3 and waits; write enable adds the T4 low half
	function automatic note_s mk(input cycle_e k, input logic [1:0] w);
		logic [7:0] len;
		len = 8'(40 + 20 * w);
		mk = '{w, k[KIND_MEM_BIT], k[KIND_WR_BIT], 8'h0, 8'h0, 8'h0, len};
		if (k == CYC_IRQ_ACK)
			mk.ack_len = len;
		else if (k[KIND_WR_BIT]) begin
			mk.wr_len = len;
			mk.en_len = len + 8'ha;
		end else
			mk.rd_len = len;
	endfunction

	task issue(input cycle_e k, input logic [1:0] w);
		waitfor(0, 1'b1);
		req_kind = k;
		req_valid = 1'b1;
		exp_q.push_back(mk(k, w));
		@(negedge ref_clk);
		req_valid = 1'b0;
	endtask

	// Done is compared before a new latch pulse restarts the counts
	always @(negedge ref_clk) begin
		if (cycle_done === 1'b1) begin
			cur = exp_q.pop_front();
			check("select", m_sel, cur.sel);
			check("direction", m_dir, cur.dir);
			check("read strobe", rd, cur.rd_len);
			check("write strobe", wr, cur.wr_len);
			check("ack strobe", ak, cur.ack_len);
			check("enable", en, cur.en_len);
		end
		if (ale === 1'b1 && !ale_d) begin
			{m_sel, m_dir, rd, wr, ak, en} = {ctl_o.mem_io_sel, ctl_o.xcvr_direction, 32'h0};
			n_waits = exp_q.size() > 0 ? exp_q[0].waits : 2'h0;
		end else begin
			rd += 8'(ctl_o.read_strobe_n === 1'b0);
			wr += 8'(ctl_o.write_strobe_n === 1'b0);
			ak += 8'(ack_n === 1'b0);
			en += 8'(ctl_o.xcvr_enable_n === 1'b0);
		end
		ale_d = ale === 1'b1;
	end

	initial begin
		void'($urandom(43138));
		{resetn, cfg_pin, req_valid, want, ale_d, n_waits, req_kind} = {5'h08, 2'h0, CYC_MEM_RD};
		repeat (8) @(negedge ref_clk);
		resetn = 1'b1;
		for (int i = 0; i < 15; i++) begin
			repeat (($urandom % 2) * 25) @(negedge ref_clk);
			issue(kinds[i % 5], 2'($urandom % 3));
		end
		waitfor(2, 1'b1);
		for (int j = 0; j < 2; j++) begin
			repeat ($urandom % 40) @(negedge ref_clk);
			want = 1'b1;
			waitfor(1, 1'b1);
			check("grant enables", ctl_oe, CTL_NO_OE);
			check("grant pins", ctl_o, CTL_IDLE);
			check("ack in grant", ack_n, 1'b1);
			check("latch in grant", ale, 1'b0);
			if (j == 0)
				issue(kinds[$urandom % 5], 2'h1);
			repeat (40) @(negedge ref_clk);
			check("grant held", grant, 1'b1);
			want = 1'b0;
			waitfor(1, 1'b0);
			repeat (15) @(negedge ref_clk);
			check("float after grant", ctl_oe, j ? CTL_NO_OE : CTL_ALL_OE);
			if (j == 1)
				issue(CYC_IO_WR, 2'h0);
			waitfor(2, 1'b1);
		end
		cfg_pin = 1'b0;
		repeat (20) @(negedge ref_clk);
		check("max mode ready", req_ready, 1'b0);
		check("max mode enables", ctl_oe, CTL_NO_OE);
		cfg_pin = 1'b1;
		issue(CYC_MEM_RD, 2'h2);
		waitfor(2, 1'b1);
		// Request raised in T1 is granted at the middle of that cycle's T4
		issue(CYC_MEM_RD, 2'h0);
		waitfor(3, 1'b1);
		want = 1'b1;
		waitfor(1, 1'b1);
		check("grant in T4", cycle_done, 1'b1);
		want = 1'b0;
		waitfor(1, 1'b0);
		waitfor(2, 1'b1);
		end_sim();
	end
endmodule

bind min_mode_bus_control bus_ctl_props props (.REF_CLK, .RESETN, .BUS_REQUEST, .CTL_O,
	.CTL_OE, .IRQ_ACK_STROBE_N, .ADDR_LATCH, .BUS_GRANT);

// file: hw/bus_ctl_pkg.sv
// Shared types and constants for the minimum-mode bus control block
package bus_ctl_pkg;

	// Reference clock and bus T-state timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TSTATE_NS     = 200;
	// Each T-state is split into a low half and a high half
	localparam int HALF_CYCLES   = (TSTATE_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int HALF_CNT_W    = $clog2(HALF_CYCLES);
	localparam logic [HALF_CNT_W-1:0] HALF_LAST  = HALF_CNT_W'(HALF_CYCLES - 1);
	localparam logic [HALF_CNT_W-1:0] HALF_RESET = '0;

	// Pin synchroniser
	localparam int SYNC_W = 2;
	localparam int SYNC_CFG_BIT  = 0;
	localparam int SYNC_HOLD_BIT = 1;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 2'h0;

	// Phase within a T-state
	localparam logic PHASE_LOW  = 1'b0;
	localparam logic PHASE_HIGH = 1'b1;

	// Kind of bus cycle: bit 2 selects memory, bit 1 selects write
	typedef enum logic [2:0] {
		CYC_IRQ_ACK = 3'h0,
		CYC_IO_RD   = 3'h1,
		CYC_IO_WR   = 3'h2,
		CYC_MEM_RD  = 3'h5,
		CYC_MEM_WR  = 3'h6
	} cycle_e;
	localparam int KIND_MEM_BIT = 2;
	localparam int KIND_WR_BIT  = 1;

	// Bus T-states, Gray along idle_state, T1, T2, T3, T4
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_T1    = 3'h1,
		ST_T2    = 3'h3,
		ST_T3    = 3'h2,
		ST_T4    = 3'h6,
		ST_WAIT  = 3'h7,
		ST_GRANT = 3'h4
	} tstate_e;

	// A cycle waiting to be run
	typedef struct packed {
		logic   valid;
		cycle_e kind;
	} pend_s;
	localparam pend_s PEND_RESET = '{valid: 1'b0, kind: CYC_MEM_RD};

	// Control pins that float during bus grant
	typedef struct packed {
		logic mem_io_sel;
		logic xcvr_direction;
		logic xcvr_enable_n;
		logic write_strobe_n;
		logic read_strobe_n;
	} ctl_pins_s;
	localparam ctl_pins_s CTL_IDLE   = 5'h1f;
	localparam ctl_pins_s CTL_NO_OE  = 5'h00;
	localparam ctl_pins_s CTL_ALL_OE = 5'h1f;

endpackage

// file: hw/half_tick.sv
// Divider giving one enable pulse per half T-state
`timescale 1ns/1ps
module half_tick (
	input  wire logic clk,
	input  wire logic rst_n,
	output      logic tick
);
	import bus_ctl_pkg::*;

	logic [HALF_CNT_W-1:0] cnt_d;
	logic [HALF_CNT_W-1:0] cnt_q;
	logic                  tick_d;
	logic                  tick_q;

	always_comb begin
		tick_d = (cnt_q == HALF_LAST);
		cnt_d  = tick_d ? HALF_RESET : cnt_q + HALF_CNT_W'(1);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= HALF_RESET;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// file: hw/min_mode_bus_control.sv
// Minimum-mode local bus control: T-state sequencer, strobes and bus grant
//
// How it works
// - With the configuration pin high, run minimum mode and drive its control outputs.
// - Memory/IO select high for memory, low for I/O, from prior T4 to final T4.
// - Write strobe low through T2, T3 and wait states of write cycles.
// - During bus grant the select, write, direction and enable outputs float high.
// - Interrupt-acknowledge strobe low through T2, T3 and wait states of acknowledge cycles.
// - Interrupt-acknowledge strobe is always driven, never floated.
// - One address latch high pulse per bus cycle, during the clock-low half of T1.
// - Address latch output is always driven, never floated.
// - Transceiver direction high for transmit, low for receive, same window as select.
// - Transceiver enable asserted for every memory, I/O and acknowledge cycle.
// - Read and acknowledge cycles enable the transceiver from mid T2 to mid T4.
// - Write cycles enable the transceiver from start of T2 to mid T4.
// - Bus grant is raised at the middle of a T4 or idle_state.
// - Bus and control lines float in the same instant bus grant rises.
// - Bus request low drops grant; driving resumes only with the next bus cycle.
// - Read strobe low through T2, T3 and wait states of memory or I/O reads.
`timescale 1ns/1ps
module min_mode_bus_control (
	input  wire logic                   REF_CLK,
	input  wire logic                   RESETN,
	input  wire logic                   BUS_CONFIG_PIN,
	input  wire logic                   BUS_REQUEST,
	input  wire logic                   READY_IN,
	input  wire logic                   REQ_VALID,
	input  wire bus_ctl_pkg::cycle_e    REQ_KIND,
	output      logic                   REQ_READY,
	output      logic                   CYCLE_DONE,
	output      bus_ctl_pkg::ctl_pins_s CTL_O,
	output      bus_ctl_pkg::ctl_pins_s CTL_OE,
	output      logic                   IRQ_ACK_STROBE_N,
	output      logic                   ADDR_LATCH,
	output      logic                   BUS_GRANT
);
	import bus_ctl_pkg::*;

	// Timing and pin conditioning
	logic              tick;
	logic              mid_tick;
	logic              end_tick;
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_lvl;
	logic              min_mode;
	logic              hold_req;

	// Sequencer state
	tstate_e   state_d;
	tstate_e   state_q;
	logic      phase_d;
	logic      phase_q;
	cycle_e    cur_d;
	cycle_e    cur_q;
	pend_s     pend_d;
	pend_s     pend_q;
	logic      drive_d;
	logic      drive_q;
	logic      grant_d;
	logic      grant_q;
	logic      done_d;
	logic      done_q;

	// Registered pin values
	ctl_pins_s ctl_d;
	ctl_pins_s ctl_q;
	ctl_pins_s oe_d;
	ctl_pins_s oe_q;
	logic      irq_ack_strobe_n_n_d;
	logic      irq_ack_strobe_n_n_q;
	logic      ale_d;
	logic      ale_q;

	// Decode helpers for output generation
	logic      show_pend;
	cycle_e    kind_show;
	logic      in_data;
	logic      is_wr;
	logic      is_ack;
	logic      den_on;

	half_tick u_half_tick (
		.clk   (REF_CLK),
		.rst_n (RESETN),
		.tick  (tick)
	);

	// Bus request is sampled like any pin even though the requester syncs it too
	assign pins_raw[SYNC_CFG_BIT]  = BUS_CONFIG_PIN;
	assign pins_raw[SYNC_HOLD_BIT] = BUS_REQUEST;

	pin_sync u_pin_sync (
		.clk   (REF_CLK),
		.rst_n (RESETN),
		.pin   (pins_raw),
		.level (pins_lvl)
	);

	assign min_mode = pins_lvl[SYNC_CFG_BIT];
	assign hold_req = pins_lvl[SYNC_HOLD_BIT];

	// Low half ends at the middle of a T-state, high half at its end
	assign mid_tick = tick && (phase_q == PHASE_LOW);
	assign end_tick = tick && (phase_q == PHASE_HIGH);

	// One pending slot; a new cycle may queue while the current one runs
	assign REQ_READY = min_mode && !pend_q.valid;

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		phase_d = tick ? ~phase_q : phase_q;
		cur_d   = cur_q;
		pend_d  = pend_q;
		drive_d = drive_q;
		grant_d = grant_q;
		done_d  = 1'b0;
		if (REQ_VALID && REQ_READY) begin
			pend_d.valid = 1'b1;
			pend_d.kind  = REQ_KIND;
		end
		if (!min_mode) begin
			// Max mode: this block stands aside completely
			state_d = ST_IDLE;
			drive_d = 1'b0;
			grant_d = 1'b0;
		end else begin
			// Select and direction become valid ahead of T1 while idle
			if (state_q == ST_IDLE && pend_q.valid) begin
				drive_d = 1'b1;
			end
			if (mid_tick) begin
				if (state_q == ST_GRANT && !hold_req) begin
					// Lines stay floated until the next cycle starts
					state_d = ST_IDLE;
					grant_d = 1'b0;
				end else if ((state_q == ST_T4 || state_q == ST_IDLE) && hold_req) begin
					// A T4 cut short by grant still completes its cycle
					if (state_q == ST_T4) begin
						done_d = 1'b1;
					end
					state_d = ST_GRANT;
					grant_d = 1'b1;
					drive_d = 1'b0;
				end
			end else if (end_tick) begin
				unique case (state_q)
					ST_IDLE, ST_T4: begin
						if (state_q == ST_T4) begin
							done_d = 1'b1;
						end
						if (pend_q.valid) begin
							state_d      = ST_T1;
							cur_d        = pend_q.kind;
							pend_d.valid = 1'b0;
							drive_d      = 1'b1;
						end else begin
							state_d = ST_IDLE;
						end
					end
					ST_T1: begin
						state_d = ST_T2;
					end
					ST_T2: begin
						state_d = ST_T3;
					end
					ST_T3, ST_WAIT: begin
						state_d = READY_IN ? ST_T4 : ST_WAIT;
					end
					ST_GRANT: begin
						state_d = ST_GRANT;
					end
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= ST_IDLE;
			phase_q <= PHASE_LOW;
			cur_q   <= CYC_MEM_RD;
			pend_q  <= PEND_RESET;
			drive_q <= 1'b0;
			grant_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			cur_q   <= cur_d;
			pend_q  <= pend_d;
			drive_q <= drive_d;
			grant_q <= grant_d;
			done_q  <= done_d;
		end
	end

	// Output values are built from the next state so pins line up with the state register
	always_comb begin
		show_pend = (state_d == ST_T4 || state_d == ST_IDLE) && pend_d.valid;
		kind_show = show_pend ? pend_d.kind : cur_d;
		in_data   = (state_d == ST_T2) || (state_d == ST_T3) || (state_d == ST_WAIT);
		is_wr     = cur_d[KIND_WR_BIT];
		is_ack    = (cur_d == CYC_IRQ_ACK);
		den_on    = ((state_d == ST_T2) && (is_wr || phase_d == PHASE_HIGH))
			|| (state_d == ST_T3) || (state_d == ST_WAIT)
			|| ((state_d == ST_T4) && phase_d == PHASE_LOW);
		ctl_d = CTL_IDLE;
		oe_d  = CTL_NO_OE;
		irq_ack_strobe_n_n_d = 1'b1;
		ale_d    = 1'b0;
		if (min_mode) begin
			ctl_d.mem_io_sel     = kind_show[KIND_MEM_BIT];
			ctl_d.xcvr_direction = kind_show[KIND_WR_BIT];
			ctl_d.xcvr_enable_n  = !den_on;
			ctl_d.write_strobe_n = !(in_data && is_wr);
			ctl_d.read_strobe_n  = !(in_data && !is_wr && !is_ack);
			irq_ack_strobe_n_n_d = !(in_data && is_ack);
			ale_d    = (state_d == ST_T1) && (phase_d == PHASE_LOW);
			if (drive_d && !grant_d) begin
				oe_d = CTL_ALL_OE;
			end
		end
		// Floated lines are driven to one internally so a pull-up sees no conflict
		if (oe_d == CTL_NO_OE) begin
			ctl_d = CTL_IDLE;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctl_q    <= CTL_IDLE;
			oe_q     <= CTL_NO_OE;
			irq_ack_strobe_n_n_q <= 1'b1;
			ale_q    <= 1'b0;
		end else begin
			ctl_q    <= ctl_d;
			oe_q     <= oe_d;
			irq_ack_strobe_n_n_q <= irq_ack_strobe_n_n_d;
			ale_q    <= ale_d;
		end
	end

	assign CTL_O            = ctl_q;
	assign CTL_OE           = oe_q;
	assign IRQ_ACK_STROBE_N = irq_ack_strobe_n_n_q;
	assign ADDR_LATCH       = ale_q;
	assign BUS_GRANT        = grant_q;
	assign CYCLE_DONE       = done_q;
endmodule

// file: hw/pin_sync.sv
// Three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic [bus_ctl_pkg::SYNC_W-1:0] pin,
	output      logic [bus_ctl_pkg::SYNC_W-1:0] level
);
	import bus_ctl_pkg::*;

	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;
	logic [SYNC_W-1:0] level_d;
	logic [SYNC_W-1:0] level_q;

	// The first stage feeds only the second; the filter sees stages two and three
	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			always_comb begin
				level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= SYNC_RESET;
			s2_q    <= SYNC_RESET;
			s3_q    <= SYNC_RESET;
			level_q <= SYNC_RESET;
		end else begin
			s1_q    <= pin;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule
